// *** instr_timing_defs.vh ***
// Opcode lengths and cycle counts for the instruction timing decoder.
`ifndef INSTR_TIMING_DEFS_VH
`define INSTR_TIMING_DEFS_VH
// ------------------------------------------------------------------
// Instruction classes
// ------------------------------------------------------------------
`define CLS_W            5
`define CLS_UNKNOWN      5'h00
`define CLS_MOV_IND_DIR  5'h01
`define CLS_MOV_IND_IMM  5'h02
`define CLS_LOAD_POINTER 5'h03
`define CLS_CODE_LOAD    5'h04
`define CLS_XDATA_8      5'h05
`define CLS_XDATA_16     5'h06
`define CLS_PUSH_POP     5'h07
`define CLS_SWAP_BANK    5'h08
`define CLS_SWAP_DIR     5'h09
`define CLS_SWAP_IND     5'h0A
`define CLS_NIBBLE_XCHG  5'h0B
`define CLS_BIT_AND      5'h0C
`define CLS_BIT_OR       5'h0D
`define CLS_BIT_MOVE     5'h0E
`define CLS_JMP_CARRY    5'h0F
`define CLS_JMP_BIT      5'h10
`define CLS_TEST_CLEAR   5'h11
`define CLS_JMP_INDIRECT 5'h12
`define CLS_SHORT_JMP    5'h13
`define CLS_JMP_ACC      5'h14
`define CLS_CMP_BRANCH   5'h15
`define CLS_ABS_BRANCH   5'h16
`define CLS_LONG_BRANCH  5'h17
`define CLS_RETURN       5'h18
// ------------------------------------------------------------------
// Lengths in bytes and cycle counts
// ------------------------------------------------------------------
`define LEN_ONE          2'h1
`define LEN_TWO          2'h2
`define LEN_THREE        2'h3
`define CYC_ONE          3'h1
`define CYC_TWO          3'h2
`define CYC_THREE        3'h3
`define CYC_FOUR         3'h4
`define CYC_FIVE         3'h5
`endif

// *** instruction_cycle_timing.v ***
// Instruction length and cycle timing decoder for the 8-bit core.
// What this block does
// - Direct or immediate move to indirect RAM: two bytes, two cycles.
// - Load data pointer with 16-bit constant: three bytes, three cycles.
// - Code byte load relative to data pointer or PC: one byte, three cycles.
// - External data move with 8-bit indirect address: one byte, three cycles.
// - External data move with data pointer address: one byte, three cycles.
// - Push and pop of a direct byte: two bytes, two cycles.
// - Swap accumulator with bank register: one byte, one cycle.
// - Low nibble exchange swaps bits 3:0 only; exchange timings as listed.
// - AND direct bit or its inverse into carry: two bytes, two cycles.
// - OR direct bit or its inverse into carry: two bytes, two cycles.
// - Move bit to carry or carry to bit: two bytes, two cycles.
// - Jump on carry set or clear: two bytes, two or three cycles.
// - Jump on direct bit set or clear: three bytes, three or four cycles.
// - Test-and-clear branch jumps on set bit and clears it; 3 bytes, 3/4.
// - Indirect jump via accumulator plus data pointer: one byte, three.
// - Short relative jump: two bytes, three cycles.
// - Jump on accumulator zero or nonzero: two bytes, two or three cycles.
// - Compare direct byte with accumulator, branch if unequal; 3 bytes, 3/4.
`timescale 1ns/1ns
`default_nettype none
`include "instr_timing_defs.vh"

module instruction_cycle_timing (
    input  wire       clk,            // System clock, 125 MHz.
    input  wire       reset_n,        // Asynchronous reset, active low.
    input  wire       op_valid,       // Opcode byte presented this cycle.
    input  wire [7:0] opcode,         // First byte of the instruction.
    input  wire [7:0] acc,            // Accumulator value.
    input  wire       carry,          // Carry flag.
    input  wire       bit_value,      // Value of the addressed direct bit.
    input  wire [7:0] direct_byte,    // Value of the direct operand byte.
    input  wire [7:0] ind_ram_byte,   // Byte addressed by indirect register.
    output reg        busy,           // Instruction in execution.
    output reg        done,           // Pulse in the last execution cycle.
    output reg  [4:0] instr_class,    // Decoded class of the instruction.
    output reg  [1:0] instr_len,      // Length in bytes.
    output reg  [2:0] instr_cycles,   // Cycle count including branch taken.
    output reg        branch_taken,   // Conditional branch is taken.
    output reg        bit_clear,      // Clear the addressed direct bit.
    output reg  [7:0] nibble_acc,     // Accumulator after nibble exchange.
    output reg  [7:0] nibble_ram      // RAM byte after nibble exchange.
);

    // --------------------------------------------------------------
    // Decode of class, length and base cycle count
    // --------------------------------------------------------------
    // Decode results for the opcode on the pins this cycle.
    reg [4:0] cls_d;
    reg [1:0] len_d;
    reg [2:0] cyc_d;
    reg       cond_d;
    reg       is_cond;

    // Classify the opcode; unlisted opcodes decode as one byte, one cycle.
    // Exact opcode matches other than long branch and return come before the
    // low-nibble test for absolute branches; those four opcodes end in two, so no listed opcode can be shadowed by that wide match.
    always @* begin
        cls_d = `CLS_UNKNOWN;
        len_d = `LEN_ONE;
        cyc_d = `CYC_ONE;
        if (opcode == 8'hA6 || opcode == 8'hA7) begin
            // Direct operand byte follows; bit 0 picks the pointer register.
            cls_d = `CLS_MOV_IND_DIR;
            len_d = `LEN_TWO;
            cyc_d = `CYC_TWO;
        end else if (opcode == 8'h76 || opcode == 8'h77) begin
            // Immediate byte follows; bit 0 picks the pointer register.
            cls_d = `CLS_MOV_IND_IMM;
            len_d = `LEN_TWO;
            cyc_d = `CYC_TWO;
        end else if (opcode == 8'h90) begin
            // Opcode plus a two-byte constant for the data pointer.
            cls_d = `CLS_LOAD_POINTER;
            len_d = `LEN_THREE;
            cyc_d = `CYC_THREE;
        end else if (opcode == 8'h93 || opcode == 8'h83) begin
            // Table read from code memory; the base is pointer or counter.
            cls_d = `CLS_CODE_LOAD;
            cyc_d = `CYC_THREE;
        end else if (opcode[7:1] == 7'h71 || opcode[7:1] == 7'h79) begin
            // Eight-bit external address from a pointer register, both ways.
            cls_d = `CLS_XDATA_8;
            cyc_d = `CYC_THREE;
        end else if (opcode == 8'hE0 || opcode == 8'hF0) begin
            // Full sixteen-bit external address from the data pointer.
            cls_d = `CLS_XDATA_16;
            cyc_d = `CYC_THREE;
        end else if (opcode == 8'hC0 || opcode == 8'hD0) begin
            // Stack transfer of one direct byte in either direction.
            cls_d = `CLS_PUSH_POP;
            len_d = `LEN_TWO;
            cyc_d = `CYC_TWO;
        end else if (opcode[7:3] == 5'h19) begin
            // Bank register swap, finished within its own cycle.
            cls_d = `CLS_SWAP_BANK;
            cyc_d = `CYC_ONE;
        end else if (opcode == 8'hC5) begin
            // Full swap with a direct byte, which needs an address byte.
            cls_d = `CLS_SWAP_DIR;
            len_d = `LEN_TWO;
            cyc_d = `CYC_TWO;
        end else if (opcode[7:1] == 7'h63) begin
            // Full swap with the byte that a pointer register addresses.
            cls_d = `CLS_SWAP_IND;
            cyc_d = `CYC_TWO;
        end else if (opcode[7:1] == 7'h6B) begin
            // Only the low nibbles trade places; the results follow below.
            cls_d = `CLS_NIBBLE_XCHG;
            cyc_d = `CYC_TWO;
        end else if (opcode == 8'h82 || opcode == 8'hB0) begin
            // Both senses of the bit AND into carry share one timing.
            cls_d = `CLS_BIT_AND;
            len_d = `LEN_TWO;
            cyc_d = `CYC_TWO;
        end else if (opcode == 8'h72 || opcode == 8'hA0) begin
            // Both senses of the bit OR into carry share one timing.
            cls_d = `CLS_BIT_OR;
            len_d = `LEN_TWO;
            cyc_d = `CYC_TWO;
        end else if (opcode == 8'hA2 || opcode == 8'h92) begin
            // Bit copy in either direction between carry and a direct bit.
            cls_d = `CLS_BIT_MOVE;
            len_d = `LEN_TWO;
            cyc_d = `CYC_TWO;
        end else if (opcode == 8'h40 || opcode == 8'h50) begin
            // Base count only; a taken jump adds its cycle further down.
            cls_d = `CLS_JMP_CARRY;
            len_d = `LEN_TWO;
            cyc_d = `CYC_TWO;
        end else if (opcode == 8'h20 || opcode == 8'h30) begin
            // Bit address and offset byte follow the opcode.
            cls_d = `CLS_JMP_BIT;
            len_d = `LEN_THREE;
            cyc_d = `CYC_THREE;
        end else if (opcode == 8'h10) begin
            // Like the bit jump, but a taken branch also clears the bit.
            cls_d = `CLS_TEST_CLEAR;
            len_d = `LEN_THREE;
            cyc_d = `CYC_THREE;
        end else if (opcode == 8'h73) begin
            // Computed jump; the target needs no operand bytes.
            cls_d = `CLS_JMP_INDIRECT;
            cyc_d = `CYC_THREE;
        end else if (opcode == 8'h80) begin
            // Unconditional, so the count never grows.
            cls_d = `CLS_SHORT_JMP;
            len_d = `LEN_TWO;
            cyc_d = `CYC_THREE;
        end else if (opcode == 8'h60 || opcode == 8'h70) begin
            // Accumulator test needs no operand, only the offset byte.
            cls_d = `CLS_JMP_ACC;
            len_d = `LEN_TWO;
            cyc_d = `CYC_TWO;
        end else if (opcode == 8'hB5) begin
            // Direct address and offset byte follow the opcode.
            cls_d = `CLS_CMP_BRANCH;
            len_d = `LEN_THREE;
            cyc_d = `CYC_THREE;
        end else if (opcode[3:0] == 4'h1) begin
            // Any opcode with low nibble one; must stay below exact matches.
            cls_d = `CLS_ABS_BRANCH;
            len_d = `LEN_TWO;
            cyc_d = `CYC_THREE;
        end else if (opcode == 8'h12 || opcode == 8'h02) begin
            // Long call and long jump carry a full sixteen-bit target.
            cls_d = `CLS_LONG_BRANCH;
            len_d = `LEN_THREE;
            cyc_d = `CYC_FOUR;
        end else if (opcode == 8'h22 || opcode == 8'h32) begin
            // Subroutine and interrupt returns share the longest count.
            cls_d = `CLS_RETURN;
            cyc_d = `CYC_FIVE;
        end
    end

    // --------------------------------------------------------------
    // Branch conditions
    // --------------------------------------------------------------
    // Opcode bit 4 selects the inverted sense within each pair.
    // Classes that do not branch keep the condition low, adding no cycle.
    always @* begin
        is_cond = 1'b1;
        cond_d  = 1'b0;
        case (cls_d)
            `CLS_JMP_CARRY:  cond_d = opcode[4] ? ~carry : carry;
            `CLS_JMP_BIT:    cond_d = opcode[4] ? ~bit_value
                                                : bit_value;
            `CLS_TEST_CLEAR: cond_d = bit_value;
            `CLS_JMP_ACC:    cond_d = opcode[4] ? (acc != 8'h00)
                                                : (acc == 8'h00);
            `CLS_CMP_BRANCH: cond_d = (direct_byte != acc);
            default:         is_cond = 1'b0;
        endcase
    end

    // --------------------------------------------------------------
    // Total cycle count
    // --------------------------------------------------------------
    reg       taken_d;
    reg [2:0] total_d;
    reg       single_d;
    reg       clear_d;

    // A taken conditional branch costs one cycle over its base count. The
    // largest count is five, so three bits hold every total.
    always @* begin
        taken_d  = is_cond & cond_d;
        total_d  = cyc_d;
        if (taken_d) begin
            total_d = cyc_d + `CYC_ONE;
        end
        single_d = (total_d == `CYC_ONE);
        clear_d  = (cls_d == `CLS_TEST_CLEAR) & bit_value;
    end

    // --------------------------------------------------------------
    // Low nibble exchange
    // --------------------------------------------------------------
    reg [7:0] swap_acc_d;
    reg [7:0] swap_ram_d;

    // Only the low four bits trade places; both high nibbles stay put.
    always @* begin
        swap_acc_d = {acc[7:4], ind_ram_byte[3:0]};
        swap_ram_d = {ind_ram_byte[7:4], acc[3:0]};
    end

    // --------------------------------------------------------------
    // Execution sequencer
    // --------------------------------------------------------------
    // Two states suffice; the count register carries the progress.
    localparam IDLE = 1'b0;
    localparam EXEC = 1'b1;

    reg       state_q;
    reg [2:0] count_q;

    // Taken conditional branches cost one extra cycle over the base count.
    // A new opcode is only accepted while idle, so overlaps cannot corrupt
    // the running count.
    // An offer made while busy is dropped without notice.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Every output reads zero until an instruction is taken.
            state_q      <= IDLE;
            count_q      <= 3'h0;
            busy         <= 1'b0;
            done         <= 1'b0;
            instr_class  <= `CLS_UNKNOWN;
            instr_len    <= 2'h0;
            instr_cycles <= 3'h0;
            branch_taken <= 1'b0;
            bit_clear    <= 1'b0;
            nibble_acc   <= 8'h00;
            nibble_ram   <= 8'h00;
        end else begin
            done      <= 1'b0;
            bit_clear <= 1'b0;
            case (state_q)
                IDLE: begin
                    // Latch the decode of an offered opcode, start its count.
                    if (op_valid) begin
                        instr_class  <= cls_d;
                        instr_len    <= len_d;
                        branch_taken <= taken_d;
                        instr_cycles <= total_d;
                        // Clear happens only when the branch is taken.
                        bit_clear    <= clear_d;
                        // The results stand until the next exchange.
                        if (cls_d == `CLS_NIBBLE_XCHG) begin
                            nibble_acc <= swap_acc_d;
                            nibble_ram <= swap_ram_d;
                        end
                        // A one-cycle instruction never leaves idle.
                        if (single_d) begin
                            done <= 1'b1;
                        end else begin
                            // The last cycle is the one that finds zero.
                            state_q <= EXEC;
                            busy    <= 1'b1;
                            count_q <= total_d - `CYC_TWO;
                        end
                    end
                end
                default: begin
                    // Count down; the edge that finds zero ends the
                    // instruction and frees the decoder for a new one.
                    if (count_q == 3'h0) begin
                        state_q <= IDLE;
                        busy    <= 1'b0;
                        done    <= 1'b1;
                    end else begin
                        count_q <= count_q - 3'h1;
                    end
                end
            endcase
        end
    end

endmodule // instruction_cycle_timing
`default_nettype wire

// *** instr_timing_chk_asserts.sv ***
// Concurrent checks on the ports of the instruction timing decoder.
`timescale 1ns/1ns
`default_nettype none
`include "instr_timing_defs.vh"
module instr_timing_chk (
    input wire logic       clk,          // Clock.
    input wire logic       reset_n,      // Reset, active low.
    input wire logic       op_valid,     // Opcode offered.
    input wire logic [7:0] acc,          // Accumulator.
    input wire logic [7:0] ind_ram_byte, // Indirect RAM byte.
    input wire logic       busy,         // Executing.
    input wire logic       done,         // Last cycle.
    input wire logic [4:0] instr_class,  // Class code.
    input wire logic [1:0] instr_len,    // Bytes.
    input wire logic [2:0] instr_cycles, // Cycles.
    input wire logic       branch_taken, // Branch taken.
    input wire logic       bit_clear,    // Bit clear pulse.
    input wire logic [7:0] nibble_acc,   // Exchanged accumulator.
    input wire logic [7:0] nibble_ram    // Exchanged RAM byte.
);
    // ------------------------------------------------------------
    // Cycle counter and properties
    // ------------------------------------------------------------
    logic [2:0] cnt_q;
    wire        take = op_valid && !busy;
    // Counts from the accepting edge; refused offers leave it alone.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cnt_q <= 3'h0;
        else if (take) cnt_q <= 3'h1;
        else if (busy) cnt_q <= cnt_q + 3'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_done_count: assert property (
        done |-> cnt_q == instr_cycles) else $error("done off count");
    a_busy_end: assert property (
        $fell(busy) |-> done) else $error("busy fell without done");
    a_two_two: assert property (
        instr_class inside {`CLS_MOV_IND_DIR, `CLS_MOV_IND_IMM,
            `CLS_PUSH_POP, `CLS_SWAP_DIR, `CLS_BIT_AND, `CLS_BIT_OR,
            `CLS_BIT_MOVE} |-> {instr_len, instr_cycles} == 5'h12)
        else $error("not two bytes two cycles");
    a_one_three: assert property (
        instr_class inside {`CLS_CODE_LOAD, `CLS_XDATA_8, `CLS_XDATA_16,
            `CLS_JMP_INDIRECT} |-> {instr_len, instr_cycles} == 5'h0B)
        else $error("not one byte three cycles");
    a_cond_short: assert property (
        instr_class inside {`CLS_JMP_CARRY, `CLS_JMP_ACC} |->
        instr_len == 2'h2 && instr_cycles == 3'h2 + branch_taken)
        else $error("short branch timing");
    a_cond_long: assert property (
        instr_class inside {`CLS_JMP_BIT, `CLS_TEST_CLEAR, `CLS_CMP_BRANCH}
        |-> instr_len == 2'h3 && instr_cycles == 3'h3 + branch_taken)
        else $error("long branch timing");
    a_nibble_result: assert property (
        take ##1 instr_class == `CLS_NIBBLE_XCHG |->
        nibble_acc == {$past(acc[7:4]), $past(ind_ram_byte[3:0])} &&
        nibble_ram == {$past(ind_ram_byte[7:4]), $past(acc[3:0])})
        else $error("nibble exchange result");
    a_clear_cause: assert property (
        bit_clear |-> instr_class == `CLS_TEST_CLEAR && branch_taken)
        else $error("bit clear without taken test");
    c_taken: cover property (done && branch_taken);
    c_clear: cover property (bit_clear);
    c_refused: cover property (busy && op_valid);
endmodule // instr_timing_chk
bind instruction_cycle_timing instr_timing_chk chk (
    .clk(clk), .reset_n(reset_n), .op_valid(op_valid), .acc(acc),
    .ind_ram_byte(ind_ram_byte), .busy(busy), .done(done),
    .instr_class(instr_class), .instr_len(instr_len),
    .instr_cycles(instr_cycles), .branch_taken(branch_taken),
    .bit_clear(bit_clear), .nibble_acc(nibble_acc),
    .nibble_ram(nibble_ram));
`default_nettype wire

// *** operand_source.sv ***
// Model of the data memories that feed operands to the decoder.
`timescale 1ns/1ns
`default_nettype none
module operand_source (
    input  wire logic       clk,                  // Clock.
    input  wire logic       busy,                 // Hold while busy.
    input  wire logic [1:0] corner,               // 1 acc zero, 2 equal.
    output var  logic [7:0] acc = 8'h00,          // Accumulator.
    output var  logic       carry = 1'b0,         // Carry flag.
    output var  logic       bit_value = 1'b0,     // Direct bit.
    output var  logic [7:0] direct_byte = 8'h00,  // Direct byte.
    output var  logic [7:0] ind_ram_byte = 8'h00  // Indirect byte.
);
    // ------------------------------------------------------------
    // Operand refresh
    // ------------------------------------------------------------
    logic [7:0] v;
    // Values change every idle cycle, so a stale sample cannot match.
    always @(negedge clk) begin
        v = 8'($urandom);
        if (!busy) begin
            acc <= (corner == 2'h1) ? 8'h00 : v;
            direct_byte <= (corner == 2'h2) ? v : 8'($urandom);
            ind_ram_byte <= 8'($urandom);
            {carry, bit_value} <= 2'($urandom);
        end
    end
endmodule // operand_source
`default_nettype wire

// *** instruction_cycle_timing_test.sv ***
// Random and corner-case bench for the instruction timing decoder.
`timescale 1ns/1ns
`default_nettype none
`include "instr_timing_defs.vh"
module instruction_cycle_timing_test;
    logic            clk = 1'b0;
    logic            reset_n = 1'b0;
    logic            op_valid = 1'b0;
    logic [7:0]      opcode = 8'h00;
    logic [1:0]      corner = 2'h0;
    wire logic [7:0] acc, direct_byte, ind_ram_byte, nibble_acc, nibble_ram;
    wire logic       carry, bit_value, busy, done, branch_taken, bit_clear;
    wire logic [4:0] instr_class;
    wire logic [1:0] instr_len;
    wire logic [2:0] instr_cycles;
    int              errors = 0;
    int              n_compared = 0;
    logic [7:0]      ops [38] = '{8'hA6, 8'h76, 8'h90, 8'h93, 8'h83, 8'hE2,
        8'hF2, 8'hE0, 8'hF0, 8'hC0, 8'hD0, 8'hC8, 8'hC5, 8'hC6, 8'hD6, 8'h82,
        8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92, 8'h40, 8'h50, 8'h20, 8'h30, 8'h10,
        8'h73, 8'h80, 8'h60, 8'h70, 8'hB5, 8'h01, 8'h11, 8'h12, 8'h02, 8'h22,
        8'h32, 8'hC3};
    // ------------------------------------------------------------
    // Design, operand model and helpers
    // ------------------------------------------------------------
    instruction_cycle_timing dut (.clk(clk), .reset_n(reset_n),
        .op_valid(op_valid), .opcode(opcode), .acc(acc), .carry(carry),
        .bit_value(bit_value), .direct_byte(direct_byte),
        .ind_ram_byte(ind_ram_byte), .busy(busy), .done(done),
        .instr_class(instr_class), .instr_len(instr_len),
        .instr_cycles(instr_cycles), .branch_taken(branch_taken),
        .bit_clear(bit_clear), .nibble_acc(nibble_acc),
        .nibble_ram(nibble_ram));
    operand_source mem (.clk(clk), .busy(busy), .corner(corner), .acc(acc),
        .carry(carry), .bit_value(bit_value), .direct_byte(direct_byte),
        .ind_ram_byte(ind_ram_byte));
    // Class, then bytes in two bits and base cycles in three.
    function automatic logic [9:0] expect_of(input logic [7:0] op);
        case (op)
            8'hA6: return {`CLS_MOV_IND_DIR, 5'h12};
            8'h76: return {`CLS_MOV_IND_IMM, 5'h12};
            8'h90: return {`CLS_LOAD_POINTER, 5'h1B};
            8'h93, 8'h83: return {`CLS_CODE_LOAD, 5'h0B};
            8'hE2, 8'hF2: return {`CLS_XDATA_8, 5'h0B};
            8'hE0, 8'hF0: return {`CLS_XDATA_16, 5'h0B};
            8'hC0, 8'hD0: return {`CLS_PUSH_POP, 5'h12};
            8'hC8: return {`CLS_SWAP_BANK, 5'h09};
            8'hC5: return {`CLS_SWAP_DIR, 5'h12};
            8'hC6: return {`CLS_SWAP_IND, 5'h0A};
            8'hD6: return {`CLS_NIBBLE_XCHG, 5'h0A};
            8'h82, 8'hB0: return {`CLS_BIT_AND, 5'h12};
            8'h72, 8'hA0: return {`CLS_BIT_OR, 5'h12};
            8'hA2, 8'h92: return {`CLS_BIT_MOVE, 5'h12};
            8'h40, 8'h50: return {`CLS_JMP_CARRY, 5'h12};
            8'h20, 8'h30: return {`CLS_JMP_BIT, 5'h1B};
            8'h10: return {`CLS_TEST_CLEAR, 5'h1B};
            8'h73: return {`CLS_JMP_INDIRECT, 5'h0B};
            8'h80: return {`CLS_SHORT_JMP, 5'h13};
            8'h60, 8'h70: return {`CLS_JMP_ACC, 5'h12};
            8'hB5: return {`CLS_CMP_BRANCH, 5'h1B};
            8'h01, 8'h11: return {`CLS_ABS_BRANCH, 5'h13};
            8'h12, 8'h02: return {`CLS_LONG_BRANCH, 5'h1C};
            8'h22, 8'h32: return {`CLS_RETURN, 5'h0D};
            default: return {`CLS_UNKNOWN, 5'h09};
        endcase
    endfunction
    // Whether a conditional branch goes, from the sampled operands.
    function automatic logic taken(input logic [7:0] op, a, d,
                                   input logic c, b);
        case (op)
            8'h40: return c;
            8'h50: return !c;
            8'h20, 8'h10: return b;
            8'h30: return !b;
            8'h60: return a == 8'h00;
            8'h70: return a != 8'h00;
            8'hB5: return a != d;
            default: return 1'b0;
        endcase
    endfunction
    task automatic check(input logic [15:0] seen, want);
        n_compared++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    // One instruction; with hold set, a return opcode is offered while busy.
    task automatic run_op(input logic [7:0] op, input logic [1:0] cr,
                          input logic hold);
        logic [9:0] e;
        logic [7:0] a, d, r;
        logic       c, b, t, clr;
        int         n;
        @(negedge clk) corner = cr;
        @(negedge clk) opcode = op;
        op_valid = 1'b1;
        @(posedge clk) {a, d, r, c, b} = {acc, direct_byte, ind_ram_byte,
                                          carry, bit_value};
        e = expect_of(op);
        t = taken(op, a, d, c, b);
        n = 0;
        clr = 1'b0;
        do begin
            @(negedge clk) n++;
            clr |= bit_clear;
            if (done === 1'b1 || !hold) op_valid = 1'b0;
            else opcode = 8'h22;
        end while (done !== 1'b1 && n < 8);
        check(instr_class, e[9:5]);
        check(instr_len, e[4:3]);
        check(instr_cycles, e[2:0] + t);
        check(16'(n), e[2:0] + t);
        check(branch_taken, t);
        check(clr, op == 8'h10 && b);
        if (op == 8'hD6) check({nibble_acc, nibble_ram},
            {a[7:4], r[3:0], r[7:4], a[3:0]});
    endtask
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial forever #4 clk = ~clk;
    // Whole table six times, with acc zero and equal operands among them.
    initial begin
        void'($urandom(32'h42376D46));
        repeat (3) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        for (int k = 0; k < 6; k++) begin
            foreach (ops[i])
                run_op(ops[i], k < 3 ? 2'(k) : 2'($urandom_range(2)), k[0]);
            $display("Opcode table pass %0d finished", k);
        end
        complete_run();
    end
    // Cuts a hang short well beyond the expected run of some 9 us.
    initial begin
        #200000;
        errors++;
        complete_run();
    end
endmodule // instruction_cycle_timing_test
`default_nettype wire
